// File: rtl/smbus_temp_pkg.sv
// Shared constants for the SMBus temperature register port
package smbus_temp_pkg;
   localparam logic [7:0] REG_TEMP_ONE = 8'h00;
   localparam logic [7:0] REG_TEMP_TWO = 8'h01;
   localparam logic [7:0] REG_CONFIG = 8'h02;
   localparam int CFG_SRC_BIT = 1;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [4:0] ADDR_BASE = 5'h09;
   localparam logic [7:0] TEMP_FLOOR = 8'h00;
endpackage

// File: rtl/smbus_bit_sampler.sv
// Line sampler giving edge and start/stop strobes for the serial bus
`timescale 1ns/1ps
module smbus_bit_sampler (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_seen,
   output logic stop_seen
);
   logic scl_q;
   logic sda_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   // Data moving while clock is high marks frame boundaries
   assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
endmodule // smbus_bit_sampler

// File: rtl/smbus_temp_register_access.sv
// SMBus slave giving byte access to the temperature registers
`timescale 1ns/1ps
// What this block does
// R1: Internal state is shown to the host as byte-wide registers over the two-wire bus.
// R2: Only write byte, read byte, send byte and receive byte transactions are served.
// R3: The slave address is one of four fixed variants picked by a two-bit strap.
// R4: Receive byte returns the register last chosen by a command byte.
// R5: Channel one temperature sits at offset 00h and channel two at 01h.
// R6: Each temperature is an unsigned byte with 1 degree per count up to 128 for the MSB.
// R7: Returned bytes go out MSB first.
// R8: Temperatures below zero read as 00h.
// R9: Bit D1 of register 02h picks the die sensor (1) or second remote diode (0) for channel two.
// R10: Both local and remote results step one degree per code.
// R11: Only the own address is acknowledged; other traffic leaves bus and pointer alone.
module smbus_temp_register_access
   import smbus_temp_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [1:0] addr_select,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic signed [8:0] temp_one_raw,
   input wire logic signed [8:0] temp_two_raw,
   output logic channel_two_local
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADDR = 7'b0000010,
      ST_AACK = 7'b0000100,
      ST_RXB = 7'b0001000,
      ST_RACK = 7'b0010000,
      ST_TXB = 7'b0100000,
      ST_TACK = 7'b1000000
   } state_t;

   state_t state_q, state_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] cnt_q, cnt_d;
   logic read_q, read_d;
   logic first_q, first_d;
   logic [7:0] ptr_q, ptr_d;
   logic [7:0] cfg_q, cfg_d;
   logic drive_q, drive_d;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   smbus_bit_sampler u_sampler (
      .clock(clock),
      .arst_n(arst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen)
   );

   // Negative codes clip to zero; 1 degree per count for both channels
   wire [7:0] temp_one_byte = temp_one_raw[8] ? TEMP_FLOOR : temp_one_raw[7:0]; // [R6] [R8] [R10]
   wire [7:0] temp_two_byte = temp_two_raw[8] ? TEMP_FLOOR : temp_two_raw[7:0]; // [R6] [R8] [R10]
   wire [6:0] own_addr = {ADDR_BASE, addr_select}; // [R3]
   wire addr_match = (shift_q[7:1] == own_addr); // [R11]
   wire [7:0] read_data = (ptr_q == REG_TEMP_ONE) ? temp_one_byte : // [R5]
                          (ptr_q == REG_TEMP_TWO) ? temp_two_byte : // [R5]
                          (ptr_q == REG_CONFIG) ? cfg_q : 8'h00; // [R1]
   assign channel_two_local = cfg_q[CFG_SRC_BIT]; // [R9]
   assign sda_out = 1'b0;
   assign sda_oe = drive_q;

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      read_d = read_q;
      first_d = first_q;
      ptr_d = ptr_q;
      cfg_d = cfg_q;
      drive_d = drive_q;
      if (start_seen) begin
         state_d = ST_ADDR;
         cnt_d = 4'h0;
         drive_d = 1'b0;
      end else if (stop_seen) begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_in};
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  if (addr_match) begin // [R11]
                     read_d = shift_q[0];
                     drive_d = 1'b1;
                     state_d = ST_AACK;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (read_q) begin
                     // Receive byte and the read half of read byte use the pointer [R4]
                     shift_d = read_data;
                     drive_d = ~read_data[7]; // [R7]
                     state_d = ST_TXB;
                  end else begin
                     drive_d = 1'b0;
                     first_d = 1'b1;
                     state_d = ST_RXB;
                  end
               end
            end
            ST_RXB: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_in};
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  drive_d = 1'b1;
                  state_d = ST_RACK;
                  if (first_q) begin
                     ptr_d = shift_q; // [R2] [R4]
                  end else if (ptr_q == REG_CONFIG) begin
                     cfg_d = shift_q; // [R9]
                  end
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  drive_d = 1'b0;
                  cnt_d = 4'h0;
                  // Write byte ends after one data byte; extras are NACKed
                  state_d = first_q ? ST_RXB : ST_IDLE; // [R2]
                  first_d = 1'b0;
               end
            end
            ST_TXB: begin
               if (scl_fall) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     drive_d = 1'b0;
                     state_d = ST_TACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     drive_d = ~shift_q[6]; // [R7]
                  end
               end
            end
            ST_TACK: begin
               // Single byte per read; host NACK then stop
               if (scl_fall) begin
                  state_d = ST_IDLE; // [R2]
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         read_q <= 1'b0;
         first_q <= 1'b0;
         ptr_q <= POINTER_RESET;
         cfg_q <= CONFIG_RESET;
         drive_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         read_q <= read_d;
         first_q <= first_d;
         ptr_q <= ptr_d;
         cfg_q <= cfg_d;
         drive_q <= drive_d;
      end
   end

   // Steps of a transfer that the checks below hang on
   sequence addr_end_foreign;
      state_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && !addr_match;
   endsequence
   sequence addr_end_own;
      state_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && addr_match
      && !start_seen && !stop_seen;
   endsequence
   sequence read_begin;
      state_q == ST_AACK && scl_fall && read_q && !start_seen && !stop_seen;
   endsequence
   sequence read_last_bit;
      state_q == ST_TXB && scl_fall && cnt_q == 4'h7 && !start_seen && !stop_seen;
   endsequence
   sequence config_byte_end;
      state_q == ST_RXB && scl_fall && cnt_q == 4'h8 && !first_q && ptr_q == REG_CONFIG
      && !start_seen && !stop_seen;
   endsequence

   a_foreign_silent: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
      addr_end_foreign |=> !sda_oe)
      else $error("Foreign address acknowledged");
   a_ptr_kept: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
      (state_q == ST_IDLE || state_q == ST_ADDR) |=> $stable(ptr_q))
      else $error("Pointer moved outside a command byte");
   a_cfg_source: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
      config_byte_end |=> channel_two_local == $past(shift_q[CFG_SRC_BIT]))
      else $error("Channel two source not following config write");
   a_clip_zero: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
      temp_one_raw[8] |-> temp_one_byte == 8'h00)
      else $error("Negative temperature not clipped");
   a_own_ack: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
      addr_end_own |=> sda_oe && state_q == ST_AACK)
      else $error("Own address not acknowledged");
   a_ack_stands: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
      (state_q == ST_AACK && !scl_fall && !start_seen && !stop_seen) |=> sda_oe)
      else $error("Address acknowledge dropped early");
   a_msb_first: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
      read_begin |=> sda_oe == ~$past(read_data[7]))
      else $error("First bit out is not the MSB");
   a_read_release: assert property (@(posedge clock) disable iff (!arst_n) // [R2]
      read_last_bit |=> !sda_oe && state_q == ST_TACK)
      else $error("Data line not released after the read byte");
   a_one_data_byte: assert property (@(posedge clock) disable iff (!arst_n) // [R2]
      (state_q == ST_RACK && !first_q && scl_fall && !start_seen && !stop_seen)
      |=> state_q == ST_IDLE)
      else $error("More than one data byte taken");
   a_temp_map: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
      (ptr_q == REG_TEMP_TWO) |-> read_data == temp_two_byte)
      else $error("Offset 01h not mapped to channel two");
endmodule // smbus_temp_register_access

// File: tb/smbus_host_model.sv
// Host-side model that masters the two-wire bus through an open-drain data line
`timescale 1ns/1ps
module smbus_host_model (
   input wire logic clock,
   output logic scl,
   output logic sda_drv,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Four clocks per phase, above the one the port needs
   task automatic hold;
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic cond(input logic first, input logic last);
      sda_drv = first;
      hold();
      scl = 1'b1;
      hold();
      sda_drv = last;
      hold();
   endtask
   // Data only moves a phase after the fall, so no false start or stop
   task automatic bit_x(input logic b, output logic r);
      sda_drv = b;
      hold();
      scl = 1'b1;
      hold();
      r = sda_wire;
      scl = 1'b0;
      hold();
   endtask
   task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], r);
         rx[i] = r;
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic start_c;
      cond(1'b1, 1'b0);
      scl = 1'b0;
      hold();
   endtask
   // Write byte, or send byte without data
   task automatic write_tx(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
                           input logic with_data, output logic ack);
      logic [7:0] rx;
      logic a1, a2, a3;
      start_c();
      byte_x({a, 1'b0}, rx, a1);
      byte_x(cmd, rx, a2);
      a3 = 1'b1;
      if (with_data) begin
         byte_x(d, rx, a3);
      end
      cond(1'b0, 1'b1);
      ack = a1 & a2 & a3;
   endtask
   // Read byte, or receive byte on the pointer left by earlier traffic
   task automatic read_tx(input logic [6:0] a, input logic [7:0] cmd, input logic with_cmd,
                          output logic [7:0] rx, output logic ack);
      logic a1, a2, a3, nk;
      a1 = 1'b1;
      a2 = 1'b1;
      if (with_cmd) begin
         start_c();
         byte_x({a, 1'b0}, rx, a1);
         byte_x(cmd, rx, a2);
      end
      start_c();
      byte_x({a, 1'b1}, rx, a3);
      byte_x(8'hff, rx, nk);
      cond(1'b0, 1'b1);
      // The device must have let go of the line for the host's NACK
      ack = a1 & a2 & a3 & ~nk;
   endtask
endmodule // smbus_host_model

// File: tb/test_smbus_temp_register_access.sv
// Self-checking bench for the SMBus temperature register port
`timescale 1ns/1ps
module test_smbus_temp_register_access;
   logic clock, arst_n, scl, sda_drv, sda_out, sda_oe, channel_two_local, ack;
   logic [1:0] addr_select;
   logic signed [8:0] temp_one_raw, temp_two_raw;
   logic [7:0] rx;
   int bad_count = 0, n_compared = 0, cycles = 0;
   // Pull-up on the data line; the device can only pull it low
   wire sda = sda_drv & (sda_oe ? sda_out : 1'b1);
   smbus_temp_register_access dut (.clock(clock), .arst_n(arst_n), .addr_select(addr_select),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .temp_one_raw(temp_one_raw), .temp_two_raw(temp_two_raw),
      .channel_two_local(channel_two_local));
   smbus_host_model host (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   function automatic logic [6:0] own();
      return {smbus_temp_pkg::ADDR_BASE, addr_select};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // About 25 transfers of under 500 cycles each
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic t_temps;
      host.read_tx(own(), 8'h00, 1'b1, rx, ack);
      chk(rx, 8'h19);
      host.read_tx(own(), 8'h01, 1'b1, rx, ack);
      chk(rx, 8'hf1);
      host.read_tx(own(), 8'h00, 1'b0, rx, ack);
      chk(rx, 8'hf1);
      temp_one_raw = -9'sd5;
      host.read_tx(own(), 8'h00, 1'b1, rx, ack);
      chk(rx, 8'h00);
      temp_one_raw = 9'sd128;
      host.read_tx(own(), 8'h00, 1'b1, rx, ack);
      chk(rx, 8'h80);
      temp_one_raw = 9'sd25;
      temp_two_raw = -9'sd40;
      host.read_tx(own(), 8'h01, 1'b1, rx, ack);
      chk(rx, 8'h00);
      temp_two_raw = 9'sd241;
   endtask
   task automatic t_config;
      host.write_tx(own(), 8'h02, 8'h02, 1'b1, ack);
      chk(ack, 8'h01);
      chk(channel_two_local, 8'h01);
      host.read_tx(own(), 8'h02, 1'b1, rx, ack);
      chk(rx, 8'h02);
      host.write_tx(own(), 8'h02, 8'h00, 1'b1, ack);
      chk(channel_two_local, 8'h00);
      // Temperature registers are read-only; unmapped offsets read zero
      host.write_tx(own(), 8'h00, 8'h55, 1'b1, ack);
      host.read_tx(own(), 8'h00, 1'b1, rx, ack);
      chk(rx, 8'h19);
      host.read_tx(own(), 8'h05, 1'b1, rx, ack);
      chk(rx, 8'h00);
   endtask
   // Mid-run reset clears the source bit and the pointer
   task automatic t_reset;
      host.write_tx(own(), 8'h02, 8'h02, 1'b1, ack);
      chk(channel_two_local, 8'h01);
      @(posedge clock);
      #1;
      arst_n = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      arst_n = 1'b1;
      chk(channel_two_local, 8'h00);
      host.read_tx(own(), 8'h00, 1'b0, rx, ack);
      chk(ack, 8'h01);
      chk(rx, 8'h19);
   endtask
   task automatic t_send;
      host.write_tx(own(), 8'h00, 8'h00, 1'b0, ack);
      chk(ack, 8'h01);
      host.read_tx(own(), 8'h00, 1'b0, rx, ack);
      chk(rx, 8'h19);
   endtask
   // Foreign write would set the source bit if it leaked through
   task automatic t_addr;
      for (int s = 0; s < 4; s++) begin
         addr_select = 2'(s);
         host.write_tx(own() ^ 7'h01, 8'h02, 8'h02, 1'b1, ack);
         chk(ack, 8'h00);
         chk(channel_two_local, 8'h00);
         host.read_tx(own(), 8'h00, 1'b0, rx, ack);
         chk(ack, 8'h01);
         chk(rx, 8'h19);
      end
   endtask
   initial begin
      arst_n = 1'b0;
      addr_select = 2'h0;
      temp_one_raw = 9'sd25;
      temp_two_raw = 9'sd241;
      repeat (4) @(posedge clock);
      #1;
      arst_n = 1'b1;
      t_temps();
      t_config();
      t_send();
      t_addr();
      t_reset();
      tally_and_finish();
   end
endmodule // test_smbus_temp_register_access
